/* File: design/ulpi_vendor_params.svh */
// Constants for the ID resistor and IO vendor register pair
`ifndef ULPI_VENDOR_PARAMS_SVH
`define ULPI_VENDOR_PARAMS_SVH

`define CORE_CLK_MHZ     10
`define CONV_TIME_US     282
`define CONV_CYCLES      (`CONV_TIME_US * `CORE_CLK_MHZ)
`define CONV_CNT_W       12
`define LINK_RISE_CNT    3'h3

`define ADDR_VENDOR_LO   6'h30
`define ADDR_VENDOR_HI   6'h3f
`define ADDR_CONV_WR     6'h36
`define ADDR_CONV_SET    6'h37
`define ADDR_CONV_CLR    6'h38
`define ADDR_IO_WR       6'h39
`define ADDR_IO_SET      6'h3a
`define ADDR_IO_CLR      6'h3b

`define OP_WRITE         2'h0
`define OP_SET           2'h1
`define OP_CLR           2'h2
`define OP_NONE          2'h3

`define TXCMD_REG_WRITE  2'h2
`define TXCMD_REG_READ   2'h3

`define CONV_DONE_BIT    3
`define CONV_TRIG_BIT    4
`define CONV_RSVD_BIT    5
`define CONV_IRQEN_BIT   6
`define CONV_READ_MASK   8'h7f
`define CONV_RESET       8'h00
`define CONV_RSVD_MASK   8'hdf
`define RID_CODE_HOLE    3'h6
`define RID_CODE_ERROR   3'h7

`define IO_SWAP_BIT      1
`define IO_UART_LVL_LSB  2
`define IO_PU_PLUS_BIT   4
`define IO_PU_MINUS_BIT  5
`define IO_USB_LVL_LSB   6
`define IO_READ_MASK     8'hfe
`define IO_RESET         8'h04
`define LEVEL_3V3        2'h0

`define RXCMD_ALT_INT    8'h80

`endif

/* File: design/ulpi_vendor_pkg.sv */
// Types shared by both ends of the vendor register link
package ulpi_vendor_pkg;

  typedef enum logic [8:0] {
    P_IDLE    = 9'h001,
    P_WR_NXT  = 9'h002,
    P_WR_DATA = 9'h004,
    P_WR_STP  = 9'h008,
    P_RD_NXT  = 9'h010,
    P_RD_TURN = 9'h020,
    P_RD_BACK = 9'h040,
    P_RX_TURN = 9'h080,
    P_RX_BACK = 9'h100
  } phy_state_t;

  typedef enum logic [6:0] {
    L_IDLE    = 7'h01,
    L_CMD     = 7'h02,
    L_BACKOFF = 7'h04,
    L_WDATA   = 7'h08,
    L_WSTP    = 7'h10,
    L_RWAIT   = 7'h20,
    L_RDATA   = 7'h40
  } link_state_t;

endpackage

/* File: design/ulpi_vendor_if.sv */
// Link pins between the transceiver end and the link controller end
interface ulpi_vendor_if;
  logic       ulpi_clk;
  logic       dir;
  logic       nxt;
  logic       stp;
  logic [7:0] phy_data;
  logic       phy_data_oe;
  logic [7:0] link_data;
  logic       link_data_oe;
  logic [7:0] data;

  // Shared data bus level resolved from both enables
  assign data = phy_data_oe ? phy_data :
                (link_data_oe ? link_data : 8'h00);

  modport phy (
    output ulpi_clk, dir, nxt, phy_data, phy_data_oe,
    input  stp, data
  );

  modport link (
    input  ulpi_clk, dir, nxt, data,
    output stp, link_data, link_data_oe
  );
endinterface

/* File: design/vendor_regs_phy.sv */
// Transceiver end: vendor conversion and IO registers behind the link
`include "ulpi_vendor_params.svh"

module vendor_regs_phy (
  ulpi_vendor_if.phy  ulpi,
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       uart_mode,
  input  wire logic       audio_mode,
  input  wire logic       uart_transmit_enable,
  input  wire logic       carkit_irq_enable,
  input  wire logic [2:0] id_resistor_code,
  output logic            conversion_trigger,
  output logic [2:0]      resistor_code,
  output logic            conversion_done_flag,
  output logic            line_swap,
  output logic            uart_route_swap,
  output logic [1:0]      regulator_level,
  output logic            charger_pullup_plus_line,
  output logic            charger_pullup_minus_line
);

  localparam logic [`CONV_CNT_W-1:0] CONV_LAST =
    `CONV_CNT_W'(`CONV_CYCLES - 1);

  // ****************************************
  // Address decode
  // ****************************************
  // 2'h1 selects the conversion register, 2'h2 the IO register
  function automatic logic [1:0] reg_sel(input logic [5:0] a);
    if (a >= `ADDR_CONV_WR && a <= `ADDR_CONV_CLR) begin
      reg_sel = 2'h1;
    end else if (a >= `ADDR_IO_WR && a <= `ADDR_IO_CLR) begin
      reg_sel = 2'h2;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  function automatic logic [1:0] addr_op(input logic [5:0] a);
    case (a)
      `ADDR_CONV_WR, `ADDR_IO_WR:   addr_op = `OP_WRITE;
      `ADDR_CONV_SET, `ADDR_IO_SET: addr_op = `OP_SET;
      `ADDR_CONV_CLR, `ADDR_IO_CLR: addr_op = `OP_CLR;
      default:                      addr_op = `OP_NONE;
    endcase
  endfunction

  function automatic logic [7:0] apply_op(input logic [7:0] old,
                                          input logic [7:0] wd,
                                          input logic [1:0] op);
    case (op)
      `OP_WRITE: apply_op = wd;
      `OP_SET:   apply_op = old | wd;
      `OP_CLR:   apply_op = old & ~wd;
      default:   apply_op = old;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [2:0]              div_reg,   div_next;
  logic                    stp_s1,    stp_s2;
  logic [7:0]              dat_s1,    dat_s2;
  logic [2:0]              code_s1,   code_s2;
  ulpi_vendor_pkg::phy_state_t state_reg, state_next;
  logic [5:0]              addr_reg,  addr_next;
  logic                    dir_reg,   dir_next;
  logic                    nxt_reg,   nxt_next;
  logic [7:0]              dout_reg,  dout_next;
  logic                    doe_reg,   doe_next;
  logic [7:0]              conv_reg,  conv_next;
  logic [7:0]              io_reg,    io_next;
  logic [`CONV_CNT_W-1:0]  ccnt_reg,  ccnt_next;
  logic                    irq_reg,   irq_next;
  logic [1:0]              lvl_reg,   lvl_next;
  logic                    swap_reg,  swap_next;
  logic                    uswap_reg, uswap_next;
  logic                    pup_reg,   pup_next;
  logic                    pdn_reg,   pdn_next;
  logic                    rise;
  logic                    wr_en;
  logic                    rd_clr;
  logic                    rx_sent;
  logic                    done_evt;
  logic [7:0]              rd_val;
  logic [7:0]              wr_val;
  logic [2:0]              code_fix;

  assign rise = (div_reg == `LINK_RISE_CNT);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    div_next   = div_reg + 3'h1;
    state_next = state_reg;
    addr_next  = addr_reg;
    dir_next   = dir_reg;
    nxt_next   = nxt_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    conv_next  = conv_reg;
    io_next    = io_reg;
    ccnt_next  = ccnt_reg;
    irq_next   = irq_reg;
    wr_en      = 1'b0;
    rd_clr     = 1'b0;
    rx_sent    = 1'b0;
    done_evt   = 1'b0;
    wr_val     = 8'h00;
    code_fix   = (code_s2 == `RID_CODE_HOLE) ? `RID_CODE_ERROR : code_s2;
    case (reg_sel(addr_reg))
      2'h1:    rd_val = conv_reg & `CONV_READ_MASK;
      2'h2:    rd_val = io_reg & `IO_READ_MASK;
      default: rd_val = 8'h00;
    endcase
    if (rise) begin
      case (state_reg)
        ulpi_vendor_pkg::P_IDLE: begin
          if (dat_s2[7:6] == `TXCMD_REG_WRITE) begin
            addr_next  = dat_s2[5:0];
            nxt_next   = 1'b1;
            state_next = ulpi_vendor_pkg::P_WR_NXT;
          end else if (dat_s2[7:6] == `TXCMD_REG_READ) begin
            addr_next  = dat_s2[5:0];
            nxt_next   = 1'b1;
            state_next = ulpi_vendor_pkg::P_RD_NXT;
          end else if (irq_reg) begin
            dir_next   = 1'b1;
            state_next = ulpi_vendor_pkg::P_RX_TURN;
          end
        end
        ulpi_vendor_pkg::P_WR_NXT: begin
          nxt_next   = 1'b0;
          state_next = ulpi_vendor_pkg::P_WR_DATA;
        end
        ulpi_vendor_pkg::P_WR_DATA: begin
          wr_en      = 1'b1;
          state_next = ulpi_vendor_pkg::P_WR_STP;
        end
        ulpi_vendor_pkg::P_WR_STP: begin
          if (stp_s2) begin
            state_next = ulpi_vendor_pkg::P_IDLE;
          end
        end
        ulpi_vendor_pkg::P_RD_NXT: begin
          nxt_next   = 1'b0;
          dir_next   = 1'b1;
          state_next = ulpi_vendor_pkg::P_RD_TURN;
        end
        ulpi_vendor_pkg::P_RD_TURN: begin
          dout_next  = rd_val;
          doe_next   = 1'b1;
          rd_clr     = (reg_sel(addr_reg) == 2'h1);
          state_next = ulpi_vendor_pkg::P_RD_BACK;
        end
        ulpi_vendor_pkg::P_RX_TURN: begin
          dout_next  = `RXCMD_ALT_INT;
          doe_next   = 1'b1;
          rx_sent    = 1'b1;
          state_next = ulpi_vendor_pkg::P_RX_BACK;
        end
        ulpi_vendor_pkg::P_RD_BACK, ulpi_vendor_pkg::P_RX_BACK: begin
          dir_next   = 1'b0;
          doe_next   = 1'b0;
          dout_next  = 8'h00;
          state_next = ulpi_vendor_pkg::P_IDLE;
        end
        default: begin
          dir_next   = 1'b0;
          nxt_next   = 1'b0;
          doe_next   = 1'b0;
          dout_next  = 8'h00;
          state_next = ulpi_vendor_pkg::P_IDLE;
        end
      endcase
    end
    // Register writes; conversion done flag and bit 7, and IO bit 0, are hardware owned
    if (wr_en) begin
      wr_val = apply_op(reg_sel(addr_reg) == 2'h1 ? conv_reg : io_reg,
                        dat_s2, addr_op(addr_reg));
      if (reg_sel(addr_reg) == 2'h1) begin
        conv_next = {1'b0, wr_val[6:4], conv_reg[`CONV_DONE_BIT],
                     wr_val[2:0]};
      end else if (reg_sel(addr_reg) == 2'h2) begin
        io_next = {wr_val[7:1], 1'b0};
      end
    end
    // Conversion timer runs while the trigger is set
    if (conv_reg[`CONV_TRIG_BIT]) begin
      if (ccnt_reg == CONV_LAST) begin
        done_evt  = 1'b1;
        ccnt_next = '0;
      end else begin
        ccnt_next = ccnt_reg + `CONV_CNT_W'(1);
      end
    end else begin
      ccnt_next = '0;
    end
    if (rd_clr) begin
      conv_next[`CONV_DONE_BIT] = 1'b0;
    end
    // Completion wins over a clearing read in the same cycle
    if (done_evt) begin
      conv_next[2:0]            = code_fix;
      conv_next[`CONV_DONE_BIT] = 1'b1;
      conv_next[`CONV_TRIG_BIT] = 1'b0;
    end
    if (rx_sent) begin
      irq_next = 1'b0;
    end
    if (done_evt && !conv_reg[`CONV_DONE_BIT] &&
        (conv_reg[`CONV_IRQEN_BIT] || carkit_irq_enable)) begin
      irq_next = 1'b1;
    end
    // Pin control from the IO register and the mode inputs
    swap_next  = io_reg[`IO_SWAP_BIT] & ~audio_mode;
    uswap_next = io_reg[`IO_SWAP_BIT] & uart_mode;
    pup_next   = io_reg[`IO_PU_PLUS_BIT] | uart_mode;
    pdn_next   = io_reg[`IO_PU_MINUS_BIT] | uart_mode;
    if (audio_mode) begin
      lvl_next = `LEVEL_3V3;
    end else if (uart_mode && uart_transmit_enable) begin
      lvl_next = io_reg[`IO_UART_LVL_LSB +: 2];
    end else begin
      lvl_next = io_reg[`IO_USB_LVL_LSB +: 2];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg   <= 3'h0;
      stp_s1    <= 1'b0;
      stp_s2    <= 1'b0;
      dat_s1    <= 8'h00;
      dat_s2    <= 8'h00;
      code_s1   <= 3'h0;
      code_s2   <= 3'h0;
      state_reg <= ulpi_vendor_pkg::P_IDLE;
      addr_reg  <= 6'h00;
      dir_reg   <= 1'b0;
      nxt_reg   <= 1'b0;
      dout_reg  <= 8'h00;
      doe_reg   <= 1'b0;
      conv_reg  <= `CONV_RESET;
      io_reg    <= `IO_RESET;
      ccnt_reg  <= '0;
      irq_reg   <= 1'b0;
      lvl_reg   <= `LEVEL_3V3;
      swap_reg  <= 1'b0;
      uswap_reg <= 1'b0;
      pup_reg   <= 1'b0;
      pdn_reg   <= 1'b0;
    end else begin
      div_reg   <= div_next;
      stp_s1    <= ulpi.stp;
      stp_s2    <= stp_s1;
      dat_s1    <= ulpi.data;
      dat_s2    <= dat_s1;
      code_s1   <= id_resistor_code;
      code_s2   <= code_s1;
      state_reg <= state_next;
      addr_reg  <= addr_next;
      dir_reg   <= dir_next;
      nxt_reg   <= nxt_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      conv_reg  <= conv_next;
      io_reg    <= io_next;
      ccnt_reg  <= ccnt_next;
      irq_reg   <= irq_next;
      lvl_reg   <= lvl_next;
      swap_reg  <= swap_next;
      uswap_reg <= uswap_next;
      pup_reg   <= pup_next;
      pdn_reg   <= pdn_next;
    end
  end

  assign ulpi.ulpi_clk             = div_reg[2];
  assign ulpi.dir                  = dir_reg;
  assign ulpi.nxt                  = nxt_reg;
  assign ulpi.phy_data             = dout_reg;
  assign ulpi.phy_data_oe          = doe_reg;
  assign conversion_trigger        = conv_reg[`CONV_TRIG_BIT];
  assign resistor_code             = conv_reg[2:0];
  assign conversion_done_flag      = conv_reg[`CONV_DONE_BIT];
  assign line_swap                 = swap_reg;
  assign uart_route_swap           = uswap_reg;
  assign regulator_level           = lvl_reg;
  assign charger_pullup_plus_line  = pup_reg;
  assign charger_pullup_minus_line = pdn_reg;

endmodule

/* File: design/vendor_regs_link.sv */
// Link controller end: issues immediate register reads and writes
`include "ulpi_vendor_params.svh"

module vendor_regs_link (
  ulpi_vendor_if.link ulpi,
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [5:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            req_ready,
  output logic            resp_valid,
  output logic [7:0]      resp_rdata,
  output logic            alt_int_seen
);

  // ****************************************
  // State
  // ****************************************
  logic                         clk_s1, clk_s2, clk_s3;
  logic                         dir_s1, dir_s2, dir_s3;
  logic                         nxt_s1, nxt_s2, nxt_s3;
  logic [7:0]                   dat_s1, dat_s2, dat_s3;
  ulpi_vendor_pkg::link_state_t state_reg, state_next;
  logic                         wr_reg,    wr_next;
  logic [7:0]                   cmd_reg,   cmd_next;
  logic [7:0]                   wdat_reg,  wdat_next;
  logic [7:0]                   dout_reg,  dout_next;
  logic                         doe_reg,   doe_next;
  logic                         stp_reg,   stp_next;
  logic                         resp_reg,  resp_next;
  logic [7:0]                   rdat_reg,  rdat_next;
  logic                         alt_reg,   alt_next;
  logic                         rise;
  logic                         rxcmd_alt;

  // Values at s3 are those the far end held just before its edge
  assign rise      = clk_s2 & ~clk_s3;
  assign rxcmd_alt = dir_s3 & ~nxt_s3 & dat_s3[7];
  assign req_ready = rise & ~dir_s3 &
                     (state_reg == ulpi_vendor_pkg::L_IDLE);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    wr_next    = wr_reg;
    cmd_next   = cmd_reg;
    wdat_next  = wdat_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    stp_next   = stp_reg;
    resp_next  = 1'b0;
    rdat_next  = rdat_reg;
    alt_next   = 1'b0;
    if (rise) begin
      case (state_reg)
        ulpi_vendor_pkg::L_IDLE: begin
          alt_next = rxcmd_alt;
          if (req_valid && !dir_s3) begin
            wr_next   = req_write;
            cmd_next  = {req_write ? `TXCMD_REG_WRITE : `TXCMD_REG_READ,
                         req_addr};
            wdat_next = (req_addr == `ADDR_CONV_WR ||
                         req_addr == `ADDR_CONV_SET) ?
                        (req_wdata & `CONV_RSVD_MASK) : req_wdata;
            dout_next  = {req_write ? `TXCMD_REG_WRITE : `TXCMD_REG_READ,
                          req_addr};
            doe_next   = 1'b1;
            state_next = ulpi_vendor_pkg::L_CMD;
          end
        end
        ulpi_vendor_pkg::L_CMD: begin
          if (dir_s3) begin
            doe_next   = 1'b0;
            dout_next  = 8'h00;
            state_next = ulpi_vendor_pkg::L_BACKOFF;
          end else if (nxt_s3) begin
            if (wr_reg) begin
              dout_next  = wdat_reg;
              state_next = ulpi_vendor_pkg::L_WDATA;
            end else begin
              doe_next   = 1'b0;
              dout_next  = 8'h00;
              state_next = ulpi_vendor_pkg::L_RWAIT;
            end
          end
        end
        ulpi_vendor_pkg::L_BACKOFF: begin
          alt_next = rxcmd_alt;
          if (!dir_s3) begin
            dout_next  = cmd_reg;
            doe_next   = 1'b1;
            state_next = ulpi_vendor_pkg::L_CMD;
          end
        end
        ulpi_vendor_pkg::L_WDATA: begin
          dout_next  = 8'h00;
          stp_next   = 1'b1;
          state_next = ulpi_vendor_pkg::L_WSTP;
        end
        ulpi_vendor_pkg::L_WSTP: begin
          stp_next   = 1'b0;
          doe_next   = 1'b0;
          resp_next  = 1'b1;
          state_next = ulpi_vendor_pkg::L_IDLE;
        end
        ulpi_vendor_pkg::L_RWAIT: begin
          if (dir_s3) begin
            state_next = ulpi_vendor_pkg::L_RDATA;
          end
        end
        ulpi_vendor_pkg::L_RDATA: begin
          rdat_next  = dat_s3;
          resp_next  = 1'b1;
          state_next = ulpi_vendor_pkg::L_IDLE;
        end
        default: begin
          doe_next   = 1'b0;
          stp_next   = 1'b0;
          dout_next  = 8'h00;
          state_next = ulpi_vendor_pkg::L_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_s1    <= 1'b0;
      clk_s2    <= 1'b0;
      clk_s3    <= 1'b0;
      dir_s1    <= 1'b0;
      dir_s2    <= 1'b0;
      dir_s3    <= 1'b0;
      nxt_s1    <= 1'b0;
      nxt_s2    <= 1'b0;
      nxt_s3    <= 1'b0;
      dat_s1    <= 8'h00;
      dat_s2    <= 8'h00;
      dat_s3    <= 8'h00;
      state_reg <= ulpi_vendor_pkg::L_IDLE;
      wr_reg    <= 1'b0;
      cmd_reg   <= 8'h00;
      wdat_reg  <= 8'h00;
      dout_reg  <= 8'h00;
      doe_reg   <= 1'b0;
      stp_reg   <= 1'b0;
      resp_reg  <= 1'b0;
      rdat_reg  <= 8'h00;
      alt_reg   <= 1'b0;
    end else begin
      clk_s1    <= ulpi.ulpi_clk;
      clk_s2    <= clk_s1;
      clk_s3    <= clk_s2;
      dir_s1    <= ulpi.dir;
      dir_s2    <= dir_s1;
      dir_s3    <= dir_s2;
      nxt_s1    <= ulpi.nxt;
      nxt_s2    <= nxt_s1;
      nxt_s3    <= nxt_s2;
      dat_s1    <= ulpi.data;
      dat_s2    <= dat_s1;
      dat_s3    <= dat_s2;
      state_reg <= state_next;
      wr_reg    <= wr_next;
      cmd_reg   <= cmd_next;
      wdat_reg  <= wdat_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      stp_reg   <= stp_next;
      resp_reg  <= resp_next;
      rdat_reg  <= rdat_next;
      alt_reg   <= alt_next;
    end
  end

  assign ulpi.link_data    = dout_reg;
  assign ulpi.link_data_oe = doe_reg;
  assign ulpi.stp          = stp_reg;
  assign resp_valid        = resp_reg;
  assign resp_rdata        = rdat_reg;
  assign alt_int_seen      = alt_reg;

endmodule

/* File: dv/vendor_regs_checker.sv */
// Concurrent checks on the vendor register link and the derived pins
module vendor_regs_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic       stp,
  input wire logic [7:0] data,
  input wire logic       phy_data_oe,
  input wire logic       link_data_oe,
  input wire logic       conversion_trigger,
  input wire logic       conversion_done_flag,
  input wire logic       carkit_irq_enable,
  input wire logic       uart_mode,
  input wire logic       audio_mode,
  input wire logic [1:0] regulator_level,
  input wire logic       line_swap,
  input wire logic       charger_pullup_plus_line,
  input wire logic       charger_pullup_minus_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Conversion length counter
  // ****************************************
  logic [11:0] busy_reg;
  logic [11:0] busy_next;

  always_comb busy_next = conversion_trigger ? busy_reg + 12'h1 : 12'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busy_reg <= 12'h000;
    else busy_reg <= busy_next;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence held8(s);
    s[*8] ##1 !s;
  endsequence
  sequence rx_alt;
    dir && phy_data_oe && data == 8'h80;
  endsequence

  nxt_width_a: assert property ($rose(nxt) |-> held8(nxt))
    else $error("nxt not one link period");
  stp_width_a: assert property ($rose(stp) |-> held8(stp))
    else $error("stp not one link period");
  dir_width_a: assert property ($rose(dir) |-> dir[*8] ##1 held8(dir))
    else $error("dir not two link periods");
  bus_owner_a: assert property (phy_data_oe |-> dir && !link_data_oe)
    else $error("data bus driven by both ends");
  done_time_a: assert property ($rose(conversion_done_flag) |->
    $fell(conversion_trigger) && busy_reg inside {[12'hb02:12'hb06]})
    else $error("conversion length or trigger clear wrong");
  done_read_a: assert property ($fell(conversion_done_flag) |-> dir)
    else $error("done flag cleared outside a read");
  alt_int_a: assert property ($rose(conversion_done_flag) &&
    carkit_irq_enable |-> ##[1:80] rx_alt)
    else $error("no alt_int receive command after done");
  uart_pull_a: assert property (uart_mode |=>
    charger_pullup_plus_line && charger_pullup_minus_line)
    else $error("pull-ups not forced in uart mode");
  audio_fix_a: assert property (audio_mode |=>
    regulator_level == 2'h0 && !line_swap)
    else $error("audio mode level or swap wrong");
endmodule

/* File: dv/tb.sv */
// Self-checking bench joining both ends of the vendor register link
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'h0, rst = 1'h1, uart_mode = 1'h0;
  logic       audio_mode = 1'h0, uart_transmit_enable = 1'h0;
  logic       carkit_irq_enable = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic [2:0] id_resistor_code = 3'h0, resistor_code, code;
  logic [5:0] req_addr = 6'h00;
  logic [7:0] req_wdata = 8'h00, resp_rdata, io_m, q, d;
  logic [1:0] regulator_level, op;
  logic       conversion_trigger, conversion_done_flag, line_swap;
  logic       uart_route_swap, charger_pullup_plus_line, req_ready;
  logic       charger_pullup_minus_line, resp_valid, alt_int_seen;
  int         fails = 0, n_compared = 0, n_alt = 0, a, k;
  logic [5:0] pin_v;

  // Derived pin outputs in the order the expectation helper builds them
  assign pin_v = {line_swap, uart_route_swap, regulator_level,
                  charger_pullup_plus_line, charger_pullup_minus_line};

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (alt_int_seen === 1'h1) n_alt++;

  ulpi_vendor_if ulpi_vendor_if_i ();
  vendor_regs_phy vendor_regs_phy_i (.ulpi(ulpi_vendor_if_i.phy), .core_clk,
    .rst, .uart_mode, .audio_mode, .uart_transmit_enable, .carkit_irq_enable,
    .id_resistor_code, .conversion_trigger, .resistor_code,
    .conversion_done_flag, .line_swap, .uart_route_swap, .regulator_level,
    .charger_pullup_plus_line, .charger_pullup_minus_line);
  vendor_regs_link vendor_regs_link_i (.ulpi(ulpi_vendor_if_i.link),
    .core_clk, .rst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .resp_valid, .resp_rdata, .alt_int_seen);
  vendor_regs_checker vendor_regs_checker_i (.core_clk, .rst,
    .dir(ulpi_vendor_if_i.dir), .nxt(ulpi_vendor_if_i.nxt),
    .stp(ulpi_vendor_if_i.stp), .data(ulpi_vendor_if_i.data),
    .phy_data_oe(ulpi_vendor_if_i.phy_data_oe),
    .link_data_oe(ulpi_vendor_if_i.link_data_oe), .conversion_trigger,
    .conversion_done_flag, .carkit_irq_enable, .uart_mode, .audio_mode,
    .regulator_level, .line_swap, .charger_pullup_plus_line,
    .charger_pullup_minus_line);

  // ****************************************
  // Expectation helpers and bus task
  // ****************************************
  function automatic logic [7:0] io_upd(logic [7:0] o, logic [1:0] p,
                                        logic [7:0] v);
    return p == 2'h0 ? v & 8'hfe : p == 2'h1 ? o | (v & 8'hfe) : o & ~v;
  endfunction
  function automatic logic [5:0] pins(logic [7:0] r);
    return {r[1] & ~audio_mode, r[1] & uart_mode, audio_mode ? 2'h0 :
            uart_mode & uart_transmit_enable ? r[3:2] : r[7:6],
            r[4] | uart_mode, r[5] | uart_mode};
  endfunction

  task automatic access(input logic w, input logic [5:0] ad,
                        input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge core_clk);
    #1;
    req_valid = 1'h1;
    req_write = w;
    req_addr = ad;
    req_wdata = wd;
    n = 0;
    do @(negedge core_clk); while (req_ready !== 1'h1 && ++n < 100);
    if (n >= 100) fails++;
    @(posedge core_clk);
    #1;
    req_valid = 1'h0;
    req_wdata = ~wd;
    n = 0;
    do @(negedge core_clk); while (resp_valid !== 1'h1 && ++n < 200);
    if (n >= 200) fails++;
    rd = resp_rdata;
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #4000000;
    fails++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hba0b9ee8));
    repeat (6) @(posedge core_clk);
    #1 rst = 1'h0;
    io_m = 8'h04;
    access(1'h0, 6'h36, 8'h00, q);
    `CHK("conv reset", 8'h00, q)
    access(1'h0, 6'h3c, 8'h00, q);
    `CHK("unmapped read", 8'h00, q)
    for (int i = 0; i < 3; i++) begin
      access(1'h1, 6'h38, 8'hff, q);
      @(posedge core_clk);
      #1;
      id_resistor_code = 3'($urandom);
      carkit_irq_enable = i == 1;
      code = id_resistor_code == 3'h6 ? 3'h7 : id_resistor_code;
      a = n_alt;
      access(1'h1, i == 1 ? 6'h37 : 6'h36, {1'h0, i == 0, 6'h30}, q);
      k = 0;
      while (conversion_done_flag !== 1'h1 && k++ < 4000) @(posedge core_clk);
      if (k > 4000) fails++;
      repeat (100) @(posedge core_clk);
      `CHK("alt int", i < 2, n_alt - a)
      access(1'h0, 6'h36 + 6'(i), 8'h00, q);
      `CHK("conv read", {1'h0, i == 0, 2'h0, 1'h1, code}, q)
      `CHK("mirror code", code, resistor_code)
      access(1'h0, 6'h36, 8'h00, q);
      `CHK("done cleared", 1'h0, q[3])
    end
    access(1'h0, 6'h3b, 8'h00, q);
    `CHK("io reset", 8'h04, q)
    for (int i = 0; i < 24; i++) begin
      op = 2'($urandom_range(2));
      d = 8'($urandom);
      access(1'h1, 6'h39 + 6'(op), d, q);
      io_m = io_upd(io_m, op, d);
      @(posedge core_clk);
      #1;
      {uart_mode, audio_mode, uart_transmit_enable} = 3'($urandom);
      access(1'h0, 6'h39 + 6'($urandom_range(2)), 8'h00, q);
      `CHK("io read", io_m, q)
      `CHK("pins", pins(io_m), pin_v)
    end
    // Enter UART mode and apply a reset pulse in mid-run
    @(posedge core_clk);
    #1;
    uart_mode = 1'h1;
    audio_mode = 1'h0;
    uart_transmit_enable = 1'h1;
    rst = 1'h1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'h0;
    io_m = 8'h04;
    access(1'h0, 6'h39, 8'h00, q);
    `CHK("io after reset", io_m, q)
    `CHK("pins after reset", pins(io_m), pin_v)
    summarize();
  end
endmodule
